// ==== rtl/ptm_pkg.sv ====
// ptm_pkg: constants, layouts and types of the pulse timer
// Behaviour
// - pin carries waveform only while output enabled
// - trigger pin rising edge can start timer
// - count snapshot bytes read-only, reset zero
// - upper count read latches live lower byte
// - lower count read returns latched byte
// - period buffer, reset ones, reloads counter
// - half-written period loads previous full value
// - period change applies at next load
// - lone lower write pairs with old upper
// - duty buffer copied to working at load
// - half-written duty not copied at load
// - duty equal period gives steady active level
// - duty zero gives steady idle level
// - duty above period gives steady idle level
// - high from load to duty match, reload after one
// - output disabled leaves pin as port
// - polarity bit inverts the waveform
package ptm_pkg;

  // ------------------------------------------------
  // bus geometry and register indices
  // ------------------------------------------------
  localparam int ADDR_W = 14; // byte address width
  localparam int ADDR_LSB = 2; // word aligned registers
  localparam int IDX_W = 12; // register index width
  localparam int DATA_W = 32; // avalon data width
  localparam int BYTE_W = 8;
  localparam int CNT_W = 16; // down-counter width
  localparam int PRE_W = 8; // prescaler width
  // byte address of each register is four times its index
  localparam logic [IDX_W-1:0] IDX_CTL_HI = 12'h044;
  localparam logic [IDX_W-1:0] IDX_CTL_LO = 12'h045;
  localparam logic [IDX_W-1:0] IDX_DC_HI = 12'hFB0;
  localparam logic [IDX_W-1:0] IDX_DC_LO = 12'hFB1;
  localparam logic [IDX_W-1:0] IDX_PER_HI = 12'hFB2;
  localparam logic [IDX_W-1:0] IDX_PER_LO = 12'hFB3;
  localparam logic [IDX_W-1:0] IDX_DUTY_HI = 12'hFB4;
  localparam logic [IDX_W-1:0] IDX_DUTY_LO = 12'hFB5;

  // ------------------------------------------------
  // reset values and small constants
  // ------------------------------------------------
  localparam logic [7:0] RST_ZERO8 = 8'h00;
  localparam logic [7:0] RST_ONES8 = 8'hFF;
  localparam logic [15:0] RST_ZERO16 = 16'h0000;
  localparam logic [15:0] RST_ONES16 = 16'hFFFF;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [PRE_W-1:0] PRE_ONE = 8'h01;
  localparam logic [2:0] CKS_FCH7 = 3'h6; // first slow source
  localparam logic [3:0] DIV_STEP = 4'h1; // skips 2^6 slot
  localparam logic [8:0] MASK_ONE = 9'h001;
  // interrupt type select codes
  localparam logic [1:0] IRS_TRIG = 2'h0;
  localparam logic [1:0] IRS_BORROW = 2'h1;
  localparam logic [1:0] IRS_EDGE = 2'h2;
  localparam logic [1:0] IRS_BOTH = 2'h3;

  // ------------------------------------------------
  // types
  // ------------------------------------------------
  // upper control byte, msb first
  typedef struct packed {
    logic timer_run_enable; // timer_run_enable
    logic software_trigger; // software_trigger, reads zero
    logic one_shot_select; // one_shot_select
    logic soft_retrigger_enable; // soft_retrigger_enable
    logic [2:0] cks; // count clock select
    logic output_mask_enable; // output_mask_enable
  } ptm_ctl_hi_t;

  // lower control byte, msb first
  typedef struct packed {
    logic egs1; // trigger falling edge stops
    logic egs0; // trigger rising edge starts
    logic interrupt_enable; // interrupt_enable
    logic interrupt_flag; // interrupt_flag
    logic [1:0] irs; // event type select
    logic output_pin_enable; // output_pin_enable
    logic polarity_select; // polarity_select
  } ptm_ctl_lo_t;

  // one-hot timer states
  typedef enum logic [2:0] {
    ST_STOP = 3'b001,
    ST_WAIT = 3'b010,
    ST_RUN = 3'b100
  } ptm_state_t;

  // avalon request group
  typedef struct packed {
    logic read;
    logic write;
    logic [ADDR_W-1:0] address;
    logic [DATA_W-1:0] writedata;
    logic [3:0] byteenable;
  } ptm_avs_req_t;

  // whole state of the timer
  typedef struct packed {
    ptm_state_t state;
    ptm_ctl_hi_t ctl_hi;
    ptm_ctl_lo_t ctl_lo;
    logic [CNT_W-1:0] cnt; // live down-counter
    logic [CNT_W-1:0] cur_per; // period of this cycle
    logic [CNT_W-1:0] duty_work; // working duty
    logic [7:0] per_hi; // staged upper period byte
    logic [CNT_W-1:0] per_act; // complete period
    logic [7:0] duty_hi; // staged upper duty byte
    logic [CNT_W-1:0] duty_act; // complete duty
    logic duty_pend; // upper duty written alone
    logic [7:0] dc_lo; // latched lower count
    logic [PRE_W-1:0] pre; // prescaler
    logic trg_s1;
    logic trg_s2;
    logic trg_s3;
    logic wave; // raw waveform level
    logic eff; // last effective level
    logic pin_out;
    logic pin_oe;
    logic waitreq;
    logic [DATA_W-1:0] rdata;
  } ptm_st_t;

endpackage : ptm_pkg

// ==== rtl/ptm_timer.sv ====
// ptm_timer: 16-bit pulse timer with avalon register slave
module ptm_timer import ptm_pkg::*; (
  input wire logic sys_clk, // 10 MHz
  input wire logic arst_n,
  input wire ptm_avs_req_t avs_req,
  output logic [DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic hw_trigger_pin, // asynchronous pin
  input wire logic gpio_dout, // port data when timer off pin
  input wire logic gpio_oe, // port enable when timer off pin
  output logic pulse_output_pin_o,
  output logic pulse_output_pin_oe
);

  // ------------------------------------------------
  // state
  // ------------------------------------------------
  localparam ptm_st_t ST_INIT = '{
    state: ST_STOP,
    cur_per: RST_ONES16,
    duty_work: RST_ONES16,
    per_hi: RST_ONES8,
    per_act: RST_ONES16,
    duty_hi: RST_ONES8,
    duty_act: RST_ONES16,
    waitreq: 1'b1,
    default: '0
  };

  ptm_st_t st_q; // registered state
  ptm_st_t st_d; // next state

  // ------------------------------------------------
  // bus decode
  // ------------------------------------------------
  logic [IDX_W-1:0] idx; // register index
  logic req; // request pending
  logic take; // first edge, answer prepared
  logic done; // accepting edge
  logic wr; // write takes effect now
  logic be1; // 16-bit access
  logic [7:0] wb0; // low write byte
  logic [7:0] wb1; // second write byte
  logic rd_hi; // upper count read
  logic wr_chi; // upper control write
  ptm_ctl_hi_t wch; // written upper control
  ptm_ctl_lo_t wcl; // written lower control

  assign idx = avs_req.address[ADDR_W-1:ADDR_LSB];
  assign req = avs_req.read | avs_req.write;
  assign take = req & st_q.waitreq;
  assign done = req & ~st_q.waitreq;
  assign wr = done & avs_req.write & avs_req.byteenable[0];
  assign be1 = avs_req.byteenable[1];
  assign wb0 = avs_req.writedata[BYTE_W-1:0];
  assign wb1 = avs_req.writedata[2*BYTE_W-1:BYTE_W];
  assign rd_hi = take & avs_req.read & (idx == IDX_DC_HI);
  assign wr_chi = wr & (idx == IDX_CTL_HI);
  assign wch = ptm_ctl_hi_t'(wb0);
  assign wcl = ptm_ctl_lo_t'(wb0);

  // ------------------------------------------------
  // prescaler tick
  // ------------------------------------------------
  logic [3:0] div_k; // log2 of division
  logic [8:0] div_mask;
  logic tick; // one-cycle count enable

  // the prescaler runs free, so the first tick after a
  // start may come early by up to one count period
  assign div_k = (st_q.ctl_hi.cks < CKS_FCH7) ?
    {1'b0, st_q.ctl_hi.cks} : {1'b0, st_q.ctl_hi.cks} + DIV_STEP;
  assign div_mask = (MASK_ONE << div_k) - MASK_ONE;
  assign tick = (st_q.pre & div_mask[PRE_W-1:0]) ==
    div_mask[PRE_W-1:0];

  // ------------------------------------------------
  // triggers and timer events
  // ------------------------------------------------
  logic rise; // synchronised trigger rising edge
  logic fall; // synchronised trigger falling edge
  logic timer_run_enable_w; // run enable including this write
  logic sw_trig;
  logic hw_start;
  logic hw_stop;
  logic run_q;
  logic trig_load; // start or retrigger
  logic borrow; // counter at one on a tick
  logic load; // counter takes the period
  logic [CNT_W-1:0] cnt_dec;

  // edges look only at the second and third stages
  assign rise = st_q.trg_s2 & ~st_q.trg_s3;
  assign fall = ~st_q.trg_s2 & st_q.trg_s3;
  assign timer_run_enable_w = wr_chi ? wch.timer_run_enable : st_q.ctl_hi.timer_run_enable;
  assign sw_trig = wr_chi & wch.software_trigger & wch.timer_run_enable;
  assign hw_start = rise & st_q.ctl_lo.egs0;
  assign run_q = st_q.state == ST_RUN;
  assign hw_stop = run_q & fall & st_q.ctl_lo.egs1;
  // a running timer restarts only with retrigger enabled
  assign trig_load = (sw_trig | (hw_start & st_q.ctl_hi.timer_run_enable)) &
    (~run_q | st_q.ctl_hi.soft_retrigger_enable) & timer_run_enable_w;
  assign borrow = run_q & tick & (st_q.cnt == CNT_ONE);
  // a pin stop or a cleared run bit beats the periodic reload
  assign load = (trig_load | (borrow & ~st_q.ctl_hi.one_shot_select & ~hw_stop)) &
    timer_run_enable_w;
  assign cnt_dec = st_q.cnt - CNT_ONE;

  // ------------------------------------------------
  // output level
  // ------------------------------------------------
  logic duty_idle; // duty zero or beyond period
  logic duty_full; // duty equals period
  logic lvl; // level before polarity
  logic ev_set; // selected event for the flag

  assign duty_idle = (st_q.duty_work == RST_ZERO16) |
    (st_q.duty_work > st_q.cur_per);
  assign duty_full = st_q.duty_work == st_q.cur_per;
  // mask forces the idle level regardless of duty
  assign lvl = run_q & ~st_q.ctl_hi.output_mask_enable & ~duty_idle &
    (duty_full | st_q.wave);

  // event selection for the sticky flag
  always_comb begin
    unique case (st_q.ctl_lo.irs)
      IRS_TRIG: ev_set = trig_load;
      IRS_BORROW: ev_set = borrow;
      IRS_EDGE: ev_set = lvl & ~st_q.eff;
      IRS_BOTH: ev_set = borrow | (lvl & ~st_q.eff);
    endcase
  end

  // ------------------------------------------------
  // read mux
  // ------------------------------------------------
  // the upper address of the count, period and duty pairs also shows the lower
  // byte in bits 15:8 when byte lane 1 is enabled
  function automatic logic [DATA_W-1:0] rd_mux(
    input ptm_st_t s,
    input logic [IDX_W-1:0] i,
    input logic w16
  );
    logic [7:0] lo8;
    logic [7:0] hi8;
    lo8 = RST_ZERO8;
    hi8 = RST_ZERO8;
    case (i)
      IDX_CTL_HI: lo8 = s.ctl_hi;
      IDX_CTL_LO: lo8 = s.ctl_lo;
      IDX_DC_HI: begin
        lo8 = s.cnt[CNT_W-1:BYTE_W];
        hi8 = s.cnt[BYTE_W-1:0];
      end
      IDX_DC_LO: lo8 = s.dc_lo;
      IDX_PER_HI: begin
        lo8 = s.per_hi;
        hi8 = s.per_act[BYTE_W-1:0];
      end
      IDX_PER_LO: lo8 = s.per_act[BYTE_W-1:0];
      IDX_DUTY_HI: begin
        lo8 = s.duty_hi;
        hi8 = s.duty_act[BYTE_W-1:0];
      end
      IDX_DUTY_LO: lo8 = s.duty_act[BYTE_W-1:0];
      default: ; // unmapped reads zero
    endcase
    return {RST_ZERO16, (w16 ? hi8 : RST_ZERO8), lo8};
  endfunction

  // ------------------------------------------------
  // next state
  // ------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.pre = st_q.pre + PRE_ONE;
    // two-stage synchroniser plus edge history
    st_d.trg_s1 = hw_trigger_pin;
    st_d.trg_s2 = st_q.trg_s1;
    st_d.trg_s3 = st_q.trg_s2;
    // handshake: answer one cycle after the request
    if (take) begin
      st_d.waitreq = 1'b0;
      st_d.rdata = rd_mux(st_q, idx, be1);
    end else if (done) begin
      st_d.waitreq = 1'b1;
    end
    // upper count read freezes the lower byte
    if (rd_hi) begin
      st_d.dc_lo = st_q.cnt[BYTE_W-1:0];
    end
    // timer core
    if (!timer_run_enable_w) begin
      st_d.state = ST_STOP; // halts at once
      st_d.wave = 1'b0;
    end else if (load) begin
      st_d.state = ST_RUN;
      st_d.cnt = st_q.per_act;
      st_d.cur_per = st_q.per_act;
      // half-written duty keeps the old working value
      if (!st_q.duty_pend) begin
        st_d.duty_work = st_q.duty_act;
      end
      st_d.wave = 1'b1;
    end else if (hw_stop || (borrow && st_q.ctl_hi.one_shot_select)) begin
      st_d.state = ST_WAIT; // one shot ends or pin stops
      st_d.wave = 1'b0;
    end else if (st_q.state == ST_STOP) begin
      st_d.state = ST_WAIT; // standby for a trigger
    end else if (run_q && tick) begin
      st_d.cnt = cnt_dec;
      if (cnt_dec == st_q.duty_work) begin
        st_d.wave = 1'b0;
      end
    end
    // register writes; count bytes are never written
    if (wr) begin
      case (idx)
        IDX_CTL_HI: begin
          st_d.ctl_hi = wch;
          st_d.ctl_hi.software_trigger = 1'b0; // trigger is a pulse
        end
        IDX_CTL_LO: begin
          st_d.ctl_lo = wcl;
          // flag clears on zero, writing one keeps it
          st_d.ctl_lo.interrupt_flag = st_q.ctl_lo.interrupt_flag & wcl.interrupt_flag;
        end
        IDX_PER_HI: begin
          st_d.per_hi = wb0;
          if (be1) begin
            st_d.per_act = {wb0, wb1};
          end
        end
        IDX_PER_LO: begin
          st_d.per_act = {st_q.per_hi, wb0};
        end
        IDX_DUTY_HI: begin
          st_d.duty_hi = wb0;
          st_d.duty_pend = !be1;
          if (be1) begin
            st_d.duty_act = {wb0, wb1};
          end
        end
        IDX_DUTY_LO: begin
          st_d.duty_act = {st_q.duty_hi, wb0};
          st_d.duty_pend = 1'b0;
        end
        default: ; // unmapped writes ignored
      endcase
    end
    // an event in the clearing cycle wins
    if (ev_set) begin
      st_d.ctl_lo.interrupt_flag = 1'b1;
    end
    st_d.eff = lvl;
    // pin mux: timer level or general port
    if (st_q.ctl_lo.output_pin_enable) begin
      st_d.pin_out = lvl ^ st_q.ctl_lo.polarity_select;
      st_d.pin_oe = 1'b1;
    end else begin
      st_d.pin_out = gpio_dout;
      st_d.pin_oe = gpio_oe;
    end
  end

  // ------------------------------------------------
  // state register
  // ------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= ST_INIT;
    end else begin
      st_q <= st_d;
    end
  end

  assign avs_readdata = st_q.rdata;
  assign avs_waitrequest = st_q.waitreq;
  assign pulse_output_pin_o = st_q.pin_out;
  assign pulse_output_pin_oe = st_q.pin_oe;

  // ------------------------------------------------
  // assertions
  // ------------------------------------------------
  logic [7:0] cnt_lo; // helpers for sampled values
  logic [CNT_W-1:0] per_act_w;
  logic [CNT_W-1:0] duty_act_w;
  logic [CNT_W-1:0] duty_work_w;
  logic [7:0] per_hi_w;
  logic [7:0] dc_lo_w;
  logic polarity_select_w;
  assign cnt_lo = st_q.cnt[BYTE_W-1:0];
  assign per_act_w = st_q.per_act;
  assign duty_act_w = st_q.duty_act;
  assign duty_work_w = st_q.duty_work;
  assign per_hi_w = st_q.per_hi;
  assign dc_lo_w = st_q.dc_lo;
  assign polarity_select_w = st_q.ctl_lo.polarity_select;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  sequence s_load;
    load;
  endsequence
  sequence s_duty_half;
    load && st_q.duty_pend;
  endsequence
  sequence s_per_hi_only;
    wr && (idx == IDX_PER_HI) && !be1;
  endsequence
  sequence s_active;
    run_q && st_q.ctl_lo.output_pin_enable && !st_q.ctl_hi.output_mask_enable;
  endsequence
  // one-shot end: borrow in single mode drops to waiting
  sequence s_shot_end;
    borrow && st_q.ctl_hi.one_shot_select && timer_run_enable_w && !load;
  endsequence

  a_pin_drive: assert property (st_q.ctl_lo.output_pin_enable |=>
    pulse_output_pin_oe)
    else $error("pin not driven while output enabled");
  a_pin_port: assert property (!st_q.ctl_lo.output_pin_enable |=>
    pulse_output_pin_oe == $past(gpio_oe) &&
    pulse_output_pin_o == $past(gpio_dout))
    else $error("pin not released to port");
  a_hw_start: assert property (hw_start && st_q.ctl_hi.timer_run_enable &&
    !wr_chi && st_q.state == ST_WAIT |=> st_q.state == ST_RUN)
    else $error("trigger pin did not start timer");
  a_snap_ro: assert property (wr && idx == IDX_DC_LO |=>
    $stable(dc_lo_w))
    else $error("write changed count snapshot");
  a_snap_latch: assert property (rd_hi |=> dc_lo_w == $past(cnt_lo))
    else $error("lower count not latched");
  a_snap_read: assert property (take && avs_req.read &&
    idx == IDX_DC_LO |=> avs_readdata[7:0] == $past(dc_lo_w))
    else $error("lower count read not latched value");
  a_reload_per: assert property (s_load |=>
    st_q.cnt == $past(per_act_w) && run_q)
    else $error("counter not loaded from period");
  a_half_period: assert property (s_per_hi_only |=>
    $stable(per_act_w))
    else $error("half period write became effective");
  a_lo_pair: assert property (wr && idx == IDX_PER_LO |=>
    per_act_w == {$past(per_hi_w), $past(wb0)})
    else $error("lower period not paired with upper");
  a_duty_copy: assert property (load && !st_q.duty_pend |=>
    duty_work_w == $past(duty_act_w))
    else $error("duty not copied at load");
  a_duty_hold: assert property (s_duty_half |=>
    $stable(duty_work_w))
    else $error("half duty copied at load");
  a_full_level: assert property (s_active ##0 (duty_full &&
    !duty_idle) |=> pulse_output_pin_o == !$past(polarity_select_w))
    else $error("duty equal period not steady active");
  a_idle_level: assert property (s_active ##0 duty_idle |=>
    pulse_output_pin_o == $past(polarity_select_w))
    else $error("idle duty not steady idle level");

  // stop paths and forced levels
  a_shot_end: assert property (s_shot_end |=>
    st_q.state == ST_WAIT && !st_q.wave)
    else $error("one shot did not return to waiting");
  a_pin_stop: assert property (hw_stop && timer_run_enable_w && !load |=>
    st_q.state == ST_WAIT)
    else $error("trigger fall did not stop timer");
  a_mask_level: assert property (st_q.ctl_hi.output_mask_enable &&
    st_q.ctl_lo.output_pin_enable |=> pulse_output_pin_o == $past(polarity_select_w))
    else $error("masked pin not at idle level");
  a_wait_level: assert property (!run_q && st_q.ctl_lo.output_pin_enable |=>
    pulse_output_pin_o == $past(polarity_select_w))
    else $error("stopped pin not at idle level");

endmodule // ptm_timer

// ==== tb/ptm_timer_tb_top.sv ====
// ptm_timer_tb_top: register and waveform bench for the pulse timer
module ptm_timer_tb_top import ptm_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;

  // ------------------------------------------------
  // stimulus and observation signals
  // ------------------------------------------------
  logic sys_clk; // 10 MHz bench clock
  logic arst_n; // active low reset
  ptm_avs_req_t req; // avalon request group
  logic [DATA_W-1:0] rdata; // slave read data
  logic wreq; // slave waitrequest
  logic trg; // hardware trigger pin
  logic gdout; // port data when timer off pin
  logic goe; // port enable when timer off pin
  logic pin_o; // pin level
  logic pin_oe; // pin drive enable
  int fails; // mismatch counter
  int compares; // comparison counter
  logic [15:0] d; // scratch read data
  logic [15:0] a; // first snapshot read
  int hi; // cycles seen high in a window
  int rise; // rising edges seen in a window

  // register table walked after reset
  localparam logic [IDX_W-1:0] REG_IDX [8] = '{IDX_CTL_HI, IDX_CTL_LO,
    IDX_DC_HI, IDX_DC_LO, IDX_PER_HI, IDX_PER_LO, IDX_DUTY_HI, IDX_DUTY_LO};
  localparam logic [7:0] REG_RST [8] = '{8'h00, 8'h00, 8'h00, 8'h00,
    8'hFF, 8'hFF, 8'hFF, 8'hFF};
  // boundary duties against period 0x0010: word, polarity, level
  localparam logic [15:0] BND_WD [6] = '{16'h1000, 16'h1000, 16'h0000,
    16'h0000, 16'h2000, 16'h2000};
  localparam logic BND_POLARITY_SELECT [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
  localparam logic BND_LVL [6] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};

  // ------------------------------------------------
  // design under test
  // ------------------------------------------------
  ptm_timer ptm_timer_i (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .avs_req(req),
    .avs_readdata(rdata),
    .avs_waitrequest(wreq),
    .hw_trigger_pin(trg),
    .gpio_dout(gdout),
    .gpio_oe(goe),
    .pulse_output_pin_o(pin_o),
    .pulse_output_pin_oe(pin_oe)
  );

  // free running clock, 100 ns period
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // ------------------------------------------------
  // bus and checking tasks
  // ------------------------------------------------
  // one avalon transfer; request held until waitrequest seen low
  task automatic bus(input logic is_rd, input logic [IDX_W-1:0] idx,
                     input logic [3:0] be, input logic [15:0] wd,
                     output logic [15:0] rd_data);
    @(posedge sys_clk);
    req <= '{read: is_rd, write: !is_rd, address: {idx, 2'b00},
             writedata: {16'h0000, wd}, byteenable: be};
    // wait for the answer; only the watchdog ends a stuck slave
    do begin
      @(posedge sys_clk);
    end while (wreq !== 1'b0);
    rd_data = rdata[15:0];
    req <= '0;
  endtask

  // register write, read data dropped
  task automatic wr(input logic [IDX_W-1:0] idx, input logic [3:0] be,
                    input logic [15:0] wd);
    logic [15:0] x;
    bus(1'b0, idx, be, wd, x);
  endtask

  // register read
  task automatic rd(input logic [IDX_W-1:0] idx, input logic [3:0] be,
                    output logic [15:0] x);
    bus(1'b1, idx, be, 16'h0000, x);
  endtask

  // exact comparison on design values
  task automatic chk(input string name, input logic [15:0] exp,
                     input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  // range comparison on bench counts
  task automatic rng(input string name, input int lo, input int up,
                     input int got);
    compares++;
    if (got < lo || got > up) begin
      fails++;
      $display("mismatch %s expected %0d..%0d seen %0d", name, lo, up, got);
    end
  endtask

  // read and compare; byte reads look at the low byte only
  task automatic rchk(input logic [IDX_W-1:0] idx, input logic [3:0] be,
                      input logic [15:0] exp, input string name);
    logic [15:0] x;
    rd(idx, be, x);
    chk(name, exp, be[1] ? x : {8'h00, x[7:0]});
  endtask

  // count high cycles and rising edges of the pin over n cycles
  task automatic watch(input int n, output int h, output int r);
    logic prev;
    h = 0;
    r = 0;
    prev = pin_o;
    repeat (n) begin
      @(posedge sys_clk);
      if (pin_o === 1'b1) h++;
      if (pin_o === 1'b1 && prev === 1'b0) r++;
      prev = pin_o;
    end
  endtask

  // counts, verdict and end of run
  task automatic conclude;
    $display("counts fails %0d compares %0d", fails, compares);
    if (fails == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // watchdog: tests need well under 5000 cycles
  initial begin
    repeat (30000) @(posedge sys_clk);
    fails++;
    $display("mismatch watchdog expected done seen timeout");
    conclude();
  end

  // ------------------------------------------------
  // test sequence
  // ------------------------------------------------
  initial begin
    arst_n = 1'b0;
    req = '0;
    trg = 1'b0;
    gdout = 1'b0;
    goe = 1'b0;
    fails = 0;
    compares = 0;
    repeat (12) @(posedge sys_clk);
    arst_n <= 1'b1;
    // reset values, unmapped place, writes to read-only count
    for (int i = 0; i < 8; i++) begin
      rchk(REG_IDX[i], 4'h1, {8'h00, REG_RST[i]}, "reset");
    end
    rchk(12'h123, 4'h1, 16'h0000, "unmapped");
    wr(IDX_DC_HI, 4'h1, 16'h0055);
    wr(IDX_DC_LO, 4'h1, 16'h00AA);
    rchk(IDX_DC_HI, 4'h3, 16'h0000, "count_ro");
    $display("test reset_values done");
    // byte pairs, word writes, lone lower byte
    wr(IDX_PER_HI, 4'h1, 16'h0012);
    wr(IDX_PER_LO, 4'h1, 16'h0034);
    rchk(IDX_PER_HI, 4'h3, 16'h3412, "period_pair");
    wr(IDX_DUTY_HI, 4'h3, 16'h5678);
    rchk(IDX_DUTY_LO, 4'h1, 16'h0056, "duty_lo");
    rchk(IDX_DUTY_HI, 4'h3, 16'h5678, "duty_word");
    wr(IDX_PER_LO, 4'h1, 16'h009A);
    rchk(IDX_PER_HI, 4'h3, 16'h9A12, "period_lone_lo");
    $display("test buffers done");
    // pwm with period 16, duty 8, divide by one
    wr(IDX_PER_HI, 4'h3, 16'h1000);
    wr(IDX_DUTY_HI, 4'h3, 16'h0800);
    wr(IDX_CTL_LO, 4'h1, 16'h0002);
    wr(IDX_CTL_HI, 4'h1, 16'h00C0);
    rchk(IDX_CTL_HI, 4'h1, 16'h0080, "ctl_hi_trig_reads0");
    watch(64, hi, rise);
    rng("pwm_high", 28, 36, hi);
    rng("pwm_rise", 3, 5, rise);
    chk("pin_oe_on", 16'h0001, {15'h0000, pin_oe});
    // snapshot stays put while the live counter moves
    rchk(IDX_DC_HI, 4'h1, 16'h0000, "count_hi");
    rd(IDX_DC_LO, 4'h1, a);
    rng("count_lo", 1, 16, int'(a[7:0]));
    repeat (5) @(posedge sys_clk);
    rchk(IDX_DC_LO, 4'h1, {8'h00, a[7:0]}, "snapshot_held");
    rd(IDX_DC_HI, 4'h3, d);
    rchk(IDX_DC_LO, 4'h1, {8'h00, d[15:8]}, "snapshot_word");
    $display("test pwm_counter done");
    // half-written period keeps the old one, pair applies at load
    wr(IDX_PER_HI, 4'h1, 16'h0001);
    watch(64, hi, rise);
    rng("period_half", 3, 5, rise);
    wr(IDX_PER_LO, 4'h1, 16'h0020);
    repeat (20) @(posedge sys_clk);
    watch(64, hi, rise);
    rng("period_long", 0, 1, rise);
    wr(IDX_PER_HI, 4'h3, 16'h1000);
    repeat (300) @(posedge sys_clk);
    $display("test period_staging done");
    // boundary duties in both polarities
    for (int i = 0; i < 6; i++) begin
      wr(IDX_CTL_LO, 4'h1, {14'h0000, 1'b1, BND_POLARITY_SELECT[i]});
      wr(IDX_DUTY_HI, 4'h3, BND_WD[i]);
      repeat (40) @(posedge sys_clk);
      watch(20, hi, rise);
      rng("duty_bound", BND_LVL[i] ? 20 : 0, BND_LVL[i] ? 20 : 0,
          hi);
    end
    $display("test duty_bounds done");
    // upper duty byte alone is not taken at load
    wr(IDX_CTL_LO, 4'h1, 16'h0002);
    wr(IDX_DUTY_HI, 4'h3, 16'h1000);
    repeat (40) @(posedge sys_clk);
    wr(IDX_DUTY_HI, 4'h1, 16'h0000);
    repeat (40) @(posedge sys_clk);
    watch(20, hi, rise);
    rng("duty_half", 20, 20, hi);
    wr(IDX_DUTY_LO, 4'h1, 16'h0000);
    repeat (40) @(posedge sys_clk);
    watch(20, hi, rise);
    rng("duty_paired", 0, 0, hi);
    $display("test duty_staging done");
    // output disabled hands the pin to the port
    wr(IDX_CTL_LO, 4'h1, 16'h0000);
    @(posedge sys_clk);
    goe <= 1'b1;
    gdout <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk("port_oe", 16'h0001, {15'h0000, pin_oe});
    chk("port_out", 16'h0001, {15'h0000, pin_o});
    goe <= 1'b0;
    gdout <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk("port_oe_off", 16'h0000, {15'h0000, pin_oe});
    chk("port_out_low", 16'h0000, {15'h0000, pin_o});
    $display("test port_mode done");
    // hardware trigger starts a waiting timer
    wr(IDX_DUTY_HI, 4'h3, 16'h0800);
    wr(IDX_CTL_HI, 4'h1, 16'h0000);
    wr(IDX_CTL_LO, 4'h1, 16'h0042);
    wr(IDX_CTL_HI, 4'h1, 16'h0080);
    watch(40, hi, rise);
    rng("trig_idle", 0, 0, hi);
    @(posedge sys_clk);
    trg <= 1'b1;
    watch(8, hi, rise);
    rng("trig_start", 1, 1, rise);
    $display("test hw_trigger done");
    // falling trigger edge stops, then one shot, then mask
    wr(IDX_CTL_LO, 4'h1, 16'h00C2);
    @(posedge sys_clk);
    trg <= 1'b0;
    repeat (5) @(posedge sys_clk);
    watch(20, hi, rise);
    rng("trig_stop", 0, 0, hi);
    wr(IDX_CTL_HI, 4'h1, 16'h00E0);
    watch(40, hi, rise);
    rng("one_shot_high", 8, 8, hi);
    rng("one_shot_rise", 1, 1, rise);
    wr(IDX_CTL_HI, 4'h1, 16'h00C1);
    watch(40, hi, rise);
    rng("masked", 0, 0, hi);
    $display("test stop_shot_mask done");
    conclude();
  end

endmodule // ptm_timer_tb_top
